/* File: inc/dsp_consts.svh */
// Register offsets, field positions, reset values and encodings of the timer
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH

`define DSP_OFS_CTRL_A    8'h00
`define DSP_OFS_CTRL_B    8'h04
`define DSP_OFS_CTRL_D    8'h08
`define DSP_OFS_COUNT     8'h0C
`define DSP_OFS_CMP_A     8'h10
`define DSP_OFS_CMP_B     8'h14
`define DSP_OFS_CAPT      8'h18
`define DSP_OFS_FLAGS     8'h1C
`define DSP_OFS_FLAG_EN   8'h20
`define DSP_OFS_PIN_DIR   8'h24

`define DSP_CTLA_MODE_A   7
`define DSP_CTLA_MODE_B   5
`define DSP_CTLB_WGM_HI   4
`define DSP_CTLB_CSEL     2
`define DSP_CTLD_ROUTE_A  0
`define DSP_CTLD_ROUTE_B  1
`define DSP_PDIR_A        0
`define DSP_PDIR_B        1

`define DSP_FLG_OVF       0
`define DSP_FLG_CMP_A     1
`define DSP_FLG_CMP_B     2
`define DSP_FLG_CAPT      5

`define DSP_RST_BYTE      8'h00
`define DSP_RST_WORD      16'h0000
`define DSP_CNT_BOTTOM    16'h0000
`define DSP_CNT_ONE       16'h0001
`define DSP_CNT_MAX       16'hFFFF

`define DSP_WGM_NORMAL    4'h0
`define DSP_WGM_CTC_CMPA  4'h4
`define DSP_WGM_PFC_CAPT  4'h8
`define DSP_WGM_PFC_CMPA  4'h9
`define DSP_WGM_CTC_CAPT  4'hC

`define DSP_OM_OFF        2'h0
`define DSP_OM_TOGGLE     2'h1
`define DSP_OM_CLEAR      2'h2
`define DSP_OM_SET        2'h3

`define DSP_CSEL_DIV1     3'h1
`define DSP_CSEL_DIV8     3'h2
`define DSP_CSEL_DIV64    3'h3
`define DSP_CSEL_DIV256   3'h4
`define DSP_CSEL_DIV1024  3'h5
`define DSP_LIM_DIV1      10'h000
`define DSP_LIM_DIV8      10'h007
`define DSP_LIM_DIV64     10'h03F
`define DSP_LIM_DIV256    10'h0FF
`define DSP_LIM_DIV1024   10'h3FF

`define DSP_RESP_OKAY     2'h0
`define DSP_RESP_SLVERR   2'h2

`endif

/* File: inc/dsp_pkg.sv */
// Types shared by the dual-slope PWM timer
package dsp_pkg;

  typedef enum logic [1:0] {
    DSP_DIR_UP   = 2'b01,
    DSP_DIR_DOWN = 2'b10
  } dsp_dir_t;

  typedef logic [1:0]  dsp_resp_t;
  typedef logic [15:0] dsp_word_t;

endpackage : dsp_pkg

/* File: test/dsp_load.sv */
// External load on the two waveform pins, with pull-down resistors
`timescale 1ns/10ps
module dsp_load
(
  // Pin drivers from the timer
  input  wire logic wave_a,
  input  wire logic oe_a,
  input  wire logic wave_b,
  input  wire logic oe_b,
  // Resolved pin levels
  output      logic pin_a,
  output      logic pin_b
);
  // A released pin is pulled low by the load
  assign pin_a = oe_a ? wave_a : 1'b0;
  assign pin_b = oe_b ? wave_b : 1'b0;
endmodule : dsp_load

/* File: test/dsp_timer_asserts.sv */
// Port-level checker for the dual-slope PWM timer
`timescale 1ns/10ps
`include "dsp_consts.svh"
module dsp_timer_asserts
#(
  parameter int ADDR_W  = 8,
  parameter int PRESC_W = 10
)
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               srst,
  // Register bus
  input wire logic               awvalid,
  input wire logic               awready,
  input wire logic               wvalid,
  input wire logic               wready,
  input wire dsp_pkg::dsp_resp_t bresp,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic [ADDR_W-1:0]  araddr,
  input wire logic               arvalid,
  input wire logic               arready,
  input wire logic [31:0]        rdata,
  input wire dsp_pkg::dsp_resp_t rresp,
  input wire logic               rvalid,
  input wire logic               rready,
  // Pins and request
  input wire logic               wave_out_a_oe,
  input wire logic               wave_out_b_oe,
  input wire logic               override_a,
  input wire logic               override_b,
  input wire logic               flag_request
);
  import dsp_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_OE_A: assert property (wave_out_a_oe |-> override_a)
    else $error("pin A driven without override");
  AST_OE_B: assert property (wave_out_b_oe |-> override_b)
    else $error("pin B driven without override");
  AST_REQ_HOLD: assert property (flag_request && !bvalid
    && !(wvalid && wready) |=> flag_request)
    else $error("flag request dropped without a write");
  AST_WR_RESP: assert property (awvalid && awready && wvalid
    && wready |-> ##2 bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  AST_B_HOLD: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp))
    else $error("write response not held");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid
    && $stable(rdata) && $stable(rresp))
    else $error("read data not held");
  AST_UNMAPPED: assert property (arvalid && arready
    && araddr > 8'h24 |=> rresp == `DSP_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_BUSY: assert property ((bvalid |-> !awready && !wready)
    and (rvalid |-> !arready))
    else $error("new request accepted before response");
endmodule : dsp_timer_asserts

bind dsp_timer dsp_timer_asserts #(.ADDR_W(ADDR_W), .PRESC_W(PRESC_W))
  u_chk (.clk(clk), .srst(srst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .wave_out_a_oe(wave_out_a_oe), .wave_out_b_oe(wave_out_b_oe),
  .override_a(override_a), .override_b(override_b),
  .flag_request(flag_request));

/* File: test/tb_top.sv */
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/10ps
`include "dsp_consts.svh"
module tb_top;
  import dsp_pkg::*;
  logic        clk;
  logic        srst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  dsp_resp_t   bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  dsp_resp_t   rresp;
  logic        rvalid;
  logic        rready;
  logic        wave_a, oe_a, wave_b, oe_b, ovr_a, ovr_b, req, pin_a, pin_b;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [31:0] seed = 32'hF18A;
  // Slow master: answers valid with ready one cycle late
  bit          lazy = 1'b0;

  dsp_timer uut (.clk(clk), .srst(srst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .wave_out_a(wave_a), .wave_out_a_oe(oe_a),
    .wave_out_b(wave_b), .wave_out_b_oe(oe_b), .override_a(ovr_a),
    .override_b(ovr_b), .flag_request(req));
  dsp_load load (.wave_a(wave_a), .oe_a(oe_a), .wave_b(wave_b),
    .oe_b(oe_b), .pin_a(pin_a), .pin_b(pin_b));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  // High clocks of one dual-slope period on a PWM channel
  function automatic int hi_exp(int c, int top, bit inv, int n);
    return 2 * n * (inv ? top - c : c);
  endfunction : hi_exp

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                        input dsp_resp_t er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= !lazy;
    forever
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && !bready)
        bready <= 1'b1;
      else if (bvalid)
      begin
        chk("write response", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        break;
      end
    end
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
                        output dsp_resp_t r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= !lazy;
    forever
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && !rready)
        rready <= 1'b1;
      else if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : bus_rd

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp, input dsp_resp_t er);
    logic [31:0] d;
    dsp_resp_t   r;
    bus_rd(a, d, r);
    chk(what, exp, d);
    chk("read response", {30'h0, er}, {30'h0, r});
  endtask : rd_chk

  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] v, ha, hb;
    dsp_resp_t   r;
    int          ps, n, top, ca, cb, w;
    bit          m9, inva, invb;
    srst    = 1'b1;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd_chk("reset value", 8'(4 * i), 32'h0, `DSP_RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      v = xorshift();
      lazy = v[1];
      bus_wr(`DSP_OFS_CTRL_A, v, `DSP_RESP_OKAY);
      rd_chk("control A", `DSP_OFS_CTRL_A, v & 32'hF3, 2'h0);
    end
    lazy = 1'b0;
    bus_wr(8'h3C, 32'hFFFF_FFFF, `DSP_RESP_SLVERR);
    rd_chk("unmapped read", 8'h3C, 32'h0, `DSP_RESP_SLVERR);
    bus_wr(`DSP_OFS_CAPT, 32'h1234, `DSP_RESP_OKAY);
    wstrb <= 4'h1;
    bus_wr(`DSP_OFS_CAPT, 32'hABCD, `DSP_RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk("byte strobe", `DSP_OFS_CAPT, 32'h12CD, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      bus_wr(`DSP_OFS_PIN_DIR, {30'h0, {2{i[0]}}}, `DSP_RESP_OKAY);
      bus_wr(`DSP_OFS_CTRL_D, {30'h0, {2{i[1]}}}, `DSP_RESP_OKAY);
      bus_wr(`DSP_OFS_CTRL_A, i[2] ? 32'hA0 : 32'h0, `DSP_RESP_OKAY);
      repeat (3) @(posedge clk);
      chk("pin enable", {30'h0, {2{i == 7}}}, {30'h0, oe_a, oe_b});
      chk("override", {30'h0, {2{i[1] & i[2]}}},
          {30'h0, ovr_a, ovr_b});
    end
    // Clear-on-match mode with compare A as TOP: A toggles, B sets
    w = 5 + xorshift() % 20;
    bus_wr(`DSP_OFS_CTRL_B, 32'h0, `DSP_RESP_OKAY);
    bus_wr(`DSP_OFS_COUNT, 32'h0, `DSP_RESP_OKAY);
    bus_wr(`DSP_OFS_CMP_A, w, `DSP_RESP_OKAY);
    bus_wr(`DSP_OFS_CMP_B, w, `DSP_RESP_OKAY);
    bus_wr(`DSP_OFS_CTRL_A, 32'h70, `DSP_RESP_OKAY);
    bus_wr(`DSP_OFS_CTRL_B, 32'h09, `DSP_RESP_OKAY);
    repeat (4 * w) @(posedge clk);
    ha = 32'h0;
    hb = 32'h0;
    repeat (2 * w + 2)
    begin
      @(posedge clk);
      ha += {31'h0, pin_a};
      hb += {31'h0, pin_b};
    end
    chk("toggle time A", w + 1, ha);
    chk("set level B", 2 * w + 2, hb);
    for (int it = 0; it < 8; it++)
    begin
      v = xorshift();
      ps = (it < 2) ? 0 : v % 3;
      n = 1 << (3 * ps);
      top = (it < 2) ? 3 : 3 + xorshift() % (ps == 2 ? 4 : 38);
      m9 = (it > 1) && v[8];
      inva = (it == 1) || (it > 1 && v[9]);
      invb = (it == 1) || (it > 1 && v[10]);
      ca = (it < 2) ? 0 : xorshift() % (top + 1);
      cb = (it < 2) ? top : xorshift() % (top + 1);
      bus_wr(`DSP_OFS_CTRL_B, 32'h0, `DSP_RESP_OKAY);
      bus_wr(`DSP_OFS_COUNT, 32'h0, `DSP_RESP_OKAY);
      bus_wr(`DSP_OFS_CAPT, top, `DSP_RESP_OKAY);
      bus_wr(`DSP_OFS_CMP_A, m9 ? top : ca, `DSP_RESP_OKAY);
      bus_wr(`DSP_OFS_CMP_B, cb, `DSP_RESP_OKAY);
      v = {24'h0, m9 ? 2'h1 : {1'b1, inva}, 1'b1, invb, 3'h0, m9};
      bus_wr(`DSP_OFS_CTRL_A, v, `DSP_RESP_OKAY);
      bus_wr(`DSP_OFS_CTRL_B, 32'h10 + ps + 1, `DSP_RESP_OKAY);
      repeat (6 * n * top) @(posedge clk);
      w = (m9 ? 4 : 2) * n * top;
      ha = 32'h0;
      hb = 32'h0;
      repeat (w)
      begin
        @(posedge clk);
        ha += {31'h0, pin_a};
        hb += {31'h0, pin_b};
      end
      chk("high time A", m9 ? w / 2 : hi_exp(ca, top, inva, n), ha);
      chk("high time B", hi_exp(cb, top, invb, n) * (m9 ? 2 : 1), hb);
    end
    rd_chk("flags", `DSP_OFS_FLAGS, 32'h27, 2'h0);
    bus_wr(`DSP_OFS_CTRL_B, 32'h0, `DSP_RESP_OKAY);
    bus_wr(`DSP_OFS_FLAGS, 32'h27, `DSP_RESP_OKAY);
    rd_chk("cleared flags", `DSP_OFS_FLAGS, 32'h0, 2'h0);
    bus_rd(`DSP_OFS_COUNT, v, r);
    repeat (20) @(posedge clk);
    rd_chk("stopped counter", `DSP_OFS_COUNT, v, 2'h0);
    bus_wr(`DSP_OFS_FLAG_EN, 32'h1, `DSP_RESP_OKAY);
    chk("flag request", 32'h0, {31'h0, req});
    bus_wr(`DSP_OFS_CTRL_B, 32'h11, `DSP_RESP_OKAY);
    repeat (400) @(posedge clk);
    chk("flag request", 32'h1, {31'h0, req});
    bus_wr(`DSP_OFS_FLAG_EN, 32'h0, `DSP_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("flag request", 32'h0, {31'h0, req});
    print_verdict();
  end
endmodule : tb_top

/* File: verilog/dsp_timer.sv */
// Dual-slope PWM timer with two compare channels behind an AXI4-Lite slave
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "dsp_consts.svh"
module dsp_timer
#(
  parameter int ADDR_W  = 8,
  parameter int PRESC_W = 10
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic                  awvalid,
  output      logic                  awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output      logic                  wready,
  // AXI4-Lite write response
  output      dsp_pkg::dsp_resp_t    bresp,
  output      logic                  bvalid,
  input  wire logic                  bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic                  arvalid,
  output      logic                  arready,
  output      logic [31:0]           rdata,
  output      dsp_pkg::dsp_resp_t    rresp,
  output      logic                  rvalid,
  input  wire logic                  rready,
  // Waveform pins
  output      logic                  wave_out_a,
  output      logic                  wave_out_a_oe,
  output      logic                  wave_out_b,
  output      logic                  wave_out_b_oe,
  output      logic                  override_a,
  output      logic                  override_b,
  // Flag request
  output      logic                  flag_request
);
  import dsp_pkg::*;

  generate
    if (PRESC_W < 10 || ADDR_W < 8)
    begin : g_bad_param
      $error("dsp_timer: PRESC_W must be >= 10 and ADDR_W >= 8");
    end
  endgenerate

  logic [1:0]        output_mode_a;
  logic [1:0]        output_mode_b;
  logic [1:0]        wgm_lo;
  logic [1:0]        wgm_hi;
  logic [2:0]        clk_sel;
  logic              route_enable_a;
  logic              route_enable_b;
  logic [1:0]        pin_direction_bit;
  dsp_word_t         counter_value;
  dsp_word_t         cmp_a_buf;
  dsp_word_t         cmp_b_buf;
  dsp_word_t         compare_reg_a;
  dsp_word_t         compare_reg_b;
  dsp_word_t         capture_top_reg;
  logic [7:0]        flags;
  logic [7:0]        flag_en;
  dsp_dir_t          dir;
  logic              wave_a;
  logic              wave_b;
  logic [PRESC_W-1:0] presc;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  logic [3:0]        waveform_mode;
  logic              pfc;
  logic              non_pwm;
  dsp_word_t         top;
  logic              top_is_capt;
  logic              do_write;
  logic [32:0]       old_word;
  logic [32:0]       rd_word;
  logic [31:0]       wmask;
  logic [31:0]       wval;
  logic              cnt_wr;
  logic              run;
  logic [9:0]        lim;
  logic              timer_tick;
  logic              tick;
  logic              at_bottom;
  logic              at_top;
  logic              match_a;
  logic              match_b;
  logic              counting_up;
  logic [7:0]        flag_set;
  logic [7:0]        flag_clr;

  // Register read mux: bit 32 flags an unmapped address
  function automatic logic [32:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    case (a[7:0])
      `DSP_OFS_CTRL_A:  r[7:0] = {output_mode_a, output_mode_b,
                                  2'h0, wgm_lo};
      `DSP_OFS_CTRL_B:  r[4:0] = {wgm_hi, clk_sel};
      `DSP_OFS_CTRL_D:  r[1:0] = {route_enable_b, route_enable_a};
      `DSP_OFS_COUNT:   r[15:0] = counter_value;
      `DSP_OFS_CMP_A:   r[15:0] = cmp_a_buf;
      `DSP_OFS_CMP_B:   r[15:0] = cmp_b_buf;
      `DSP_OFS_CAPT:    r[15:0] = capture_top_reg;
      `DSP_OFS_FLAGS:   r[7:0] = flags;
      `DSP_OFS_FLAG_EN: r[7:0] = flag_en;
      `DSP_OFS_PIN_DIR: r[1:0] = pin_direction_bit;
      default:          r[32] = 1'b1;
    endcase
    if (a[ADDR_W-1:0] > ADDR_W'(8'hFF))
    begin
      r = {1'b1, 32'h0000_0000};
    end
    return r;
  endfunction : rd_mux

  // Next level of a channel output on a tick
  function automatic logic next_wave(input logic cur, input logic [1:0] om,
                                     input logic hit, input logic up,
                                     input logic is_a);
    logic n;
    n = cur;
    if (hit && pfc)
    begin
      case (om)
        `DSP_OM_TOGGLE: n = is_a ? ~cur : cur;
        `DSP_OM_CLEAR:  n = ~up;
        `DSP_OM_SET:    n = up;
        default:        n = cur;
      endcase
    end
    else if (hit && non_pwm)
    begin
      case (om)
        `DSP_OM_TOGGLE: n = ~cur;
        `DSP_OM_CLEAR:  n = 1'b0;
        `DSP_OM_SET:    n = 1'b1;
        default:        n = cur;
      endcase
    end
    return n;
  endfunction : next_wave

  assign waveform_mode = {wgm_hi, wgm_lo};
  assign pfc = (waveform_mode == `DSP_WGM_PFC_CAPT) ||
               (waveform_mode == `DSP_WGM_PFC_CMPA);
  assign non_pwm = (waveform_mode == `DSP_WGM_NORMAL) ||
                   (waveform_mode == `DSP_WGM_CTC_CMPA) ||
                   (waveform_mode == `DSP_WGM_CTC_CAPT);
  assign top_is_capt = (waveform_mode == `DSP_WGM_PFC_CAPT) ||
                       (waveform_mode == `DSP_WGM_CTC_CAPT);

  // Full 16-bit TOP source selection
  always_comb
  begin
    if (top_is_capt)
      top = capture_top_reg;
    else if (waveform_mode == `DSP_WGM_PFC_CMPA ||
             waveform_mode == `DSP_WGM_CTC_CMPA)
      top = compare_reg_a;
    else
      top = `DSP_CNT_MAX;
  end

  // Bus write merge with byte strobes
  assign do_write = !awready && !wready && !bvalid;
  // Process form so the mux follows register changes, not only the address
  always_comb
  begin
    old_word = rd_mux(aw_addr_q);
    rd_word = rd_mux(araddr);
  end
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                  {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wval = (old_word[31:0] & ~wmask) | (w_data_q & wmask);
  assign cnt_wr = do_write && (aw_addr_q[7:0] == `DSP_OFS_COUNT) &&
                  !old_word[32];

  // Prescaler
  always_comb
  begin
    run = 1'b1;
    case (clk_sel)
      `DSP_CSEL_DIV1:    lim = `DSP_LIM_DIV1;
      `DSP_CSEL_DIV8:    lim = `DSP_LIM_DIV8;
      `DSP_CSEL_DIV64:   lim = `DSP_LIM_DIV64;
      `DSP_CSEL_DIV256:  lim = `DSP_LIM_DIV256;
      `DSP_CSEL_DIV1024: lim = `DSP_LIM_DIV1024;
      default:
      begin
        lim = `DSP_LIM_DIV1;
        run = 1'b0;
      end
    endcase
  end

  assign timer_tick = run && (presc >= PRESC_W'(lim));
  assign tick = timer_tick && !cnt_wr;

  always_ff @(posedge clk)
  begin
    if (srst || !run || timer_tick)
      presc <= '0;
    else
      presc <= presc + PRESC_W'(1);
  end

  // Tick events; equality alone means no match above TOP
  assign at_bottom = tick && pfc && (counter_value == `DSP_CNT_BOTTOM);
  assign at_top = tick && (counter_value == top);
  assign match_a = tick && (counter_value == compare_reg_a);
  assign match_b = tick && (counter_value == compare_reg_b);
  assign counting_up = (counter_value == `DSP_CNT_BOTTOM) ||
                       (dir == DSP_DIR_UP && counter_value != top);

  // Counter and direction
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      counter_value <= `DSP_RST_WORD;
      dir <= DSP_DIR_UP;
    end
    else if (cnt_wr)
      counter_value <= wval[15:0];
    else if (tick && pfc)
    begin
      if (dir == DSP_DIR_UP && counter_value == top)
      begin
        counter_value <= counter_value - `DSP_CNT_ONE;
        dir <= DSP_DIR_DOWN;
      end
      else if (dir == DSP_DIR_DOWN && counter_value == `DSP_CNT_BOTTOM)
      begin
        counter_value <= `DSP_CNT_ONE;
        dir <= DSP_DIR_UP;
      end
      else if (dir == DSP_DIR_UP)
        counter_value <= counter_value + `DSP_CNT_ONE;
      else
        counter_value <= counter_value - `DSP_CNT_ONE;
    end
    else if (tick)
    begin
      dir <= DSP_DIR_UP;
      if (counter_value == top)
        counter_value <= `DSP_CNT_BOTTOM;
      else
        counter_value <= counter_value + `DSP_CNT_ONE;
    end
  end

  // Control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      output_mode_a <= `DSP_OM_OFF;
      output_mode_b <= `DSP_OM_OFF;
      wgm_lo <= 2'h0;
      wgm_hi <= 2'h0;
      clk_sel <= 3'h0;
      route_enable_a <= 1'b0;
      route_enable_b <= 1'b0;
      pin_direction_bit <= 2'h0;
      flag_en <= `DSP_RST_BYTE;
      capture_top_reg <= `DSP_RST_WORD;
    end
    else if (do_write)
    begin
      case (aw_addr_q[7:0])
        `DSP_OFS_CTRL_A:
        begin
          output_mode_a <= wval[`DSP_CTLA_MODE_A -: 2];
          output_mode_b <= wval[`DSP_CTLA_MODE_B -: 2];
          wgm_lo <= wval[1:0];
        end
        `DSP_OFS_CTRL_B:
        begin
          wgm_hi <= wval[`DSP_CTLB_WGM_HI -: 2];
          clk_sel <= wval[`DSP_CTLB_CSEL -: 3];
        end
        `DSP_OFS_CTRL_D:
        begin
          route_enable_a <= wval[`DSP_CTLD_ROUTE_A];
          route_enable_b <= wval[`DSP_CTLD_ROUTE_B];
        end
        `DSP_OFS_CAPT:    capture_top_reg <= wval[15:0];
        `DSP_OFS_FLAG_EN: flag_en <= wval[7:0];
        `DSP_OFS_PIN_DIR: pin_direction_bit <= wval[1:0];
        default:          flag_en <= flag_en;
      endcase
    end
  end

  // Compare buffers and active compare registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmp_a_buf <= `DSP_RST_WORD;
      cmp_b_buf <= `DSP_RST_WORD;
      compare_reg_a <= `DSP_RST_WORD;
      compare_reg_b <= `DSP_RST_WORD;
    end
    else
    begin
      if (do_write && aw_addr_q[7:0] == `DSP_OFS_CMP_A)
        cmp_a_buf <= wval[15:0];
      if (do_write && aw_addr_q[7:0] == `DSP_OFS_CMP_B)
        cmp_b_buf <= wval[15:0];
      if (pfc)
      begin
        if (at_bottom)
        begin
          compare_reg_a <= cmp_a_buf;
          compare_reg_b <= cmp_b_buf;
        end
      end
      else
      begin
        compare_reg_a <= cmp_a_buf;
        compare_reg_b <= cmp_b_buf;
      end
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`DSP_FLG_OVF] = pfc ? at_bottom :
                             (tick && counter_value == `DSP_CNT_MAX);
    flag_set[`DSP_FLG_CMP_A] = match_a;
    flag_set[`DSP_FLG_CMP_B] = match_b;
    flag_set[`DSP_FLG_CAPT] = at_top && top_is_capt;
    flag_clr = 8'h00;
    if (do_write && aw_addr_q[7:0] == `DSP_OFS_FLAGS)
      flag_clr = wval[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      flags <= `DSP_RST_BYTE;
    else
      flags <= (flags & ~flag_clr) | flag_set;
  end

  // Channel waveforms and pin drive
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
      wave_out_a_oe <= 1'b0;
      wave_out_b_oe <= 1'b0;
      override_a <= 1'b0;
      override_b <= 1'b0;
      flag_request <= 1'b0;
    end
    else
    begin
      wave_a <= next_wave(wave_a, output_mode_a, match_a, counting_up,
                          1'b1);
      wave_b <= next_wave(wave_b, output_mode_b, match_b, counting_up,
                          1'b0);
      wave_out_a <= wave_a;
      wave_out_b <= wave_b;
      override_a <= route_enable_a && (output_mode_a != `DSP_OM_OFF);
      override_b <= route_enable_b && (output_mode_b != `DSP_OM_OFF);
      wave_out_a_oe <= pin_direction_bit[`DSP_PDIR_A] && route_enable_a &&
                       (output_mode_a != `DSP_OM_OFF);
      wave_out_b_oe <= pin_direction_bit[`DSP_PDIR_B] && route_enable_b &&
                       (output_mode_b != `DSP_OM_OFF);
      flag_request <= |(flags & flag_en);
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `DSP_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (awready && awvalid)
      begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wready && wvalid)
      begin
        wready <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= old_word[32] ? `DSP_RESP_SLVERR : `DSP_RESP_OKAY;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DSP_RESP_OKAY;
    end
    else if (arready && arvalid)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word[31:0];
      rresp <= rd_word[32] ? `DSP_RESP_SLVERR : `DSP_RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : dsp_timer
